// ---- pkg/ncph_pkg.sv ----
package ncph_pkg;

	// Host I/O port addresses
	localparam logic [23:0] NCPH_CMD_ADDR   = 24'h8000f8;
	localparam logic [23:0] NCPH_DATA_ADDR  = 24'h8000fc;
	localparam logic [23:0] NCPH_CLEAR_ADDR = 24'h0000f0;

	localparam int NCPH_DW      = 16;
	localparam int NCPH_NEXC    = 6;
	localparam int NCPH_BUF_AW  = 3;
	localparam int NCPH_TMR_W   = 4;

	// Command word fields
	localparam int NCPH_CMD_CNT_LSB  = 0;
	localparam int NCPH_CMD_CNT_W    = 3;
	localparam int NCPH_CMD_DIR_BIT  = 3;
	localparam int NCPH_CMD_EXE_LSB  = 8;
	localparam int NCPH_CMD_CLREX    = 14;
	localparam int NCPH_CMD_LDCTL    = 15;

	// Status word fields
	localparam int NCPH_ST_EXC_LSB   = 0;
	localparam int NCPH_ST_ERR_BIT   = 7;
	localparam int NCPH_ST_BUSY_BIT  = 15;

	localparam logic [NCPH_NEXC-1:0] NCPH_MASK_RST = 6'h3f;
	localparam logic [7:0]           NCPH_CLEAR_VAL = 8'h00;

	typedef struct packed {
		logic                 wr;
		logic                 rd;
		logic [23:0]          addr;
		logic [NCPH_DW-1:0]   wdata;
	} ncph_bus_s;

	typedef enum logic [2:0] {
		NCPH_IDLE,
		NCPH_XFER,
		NCPH_EXEC,
		NCPH_FINISH,
		NCPH_HELD
	} ncph_state_e;

endpackage

// ---- verilog/ncph_timer.sv ----
`timescale 1ns/1ps
module ncph_timer
	import ncph_pkg::*;
#(
	parameter int W = NCPH_TMR_W
) (
	input  wire logic         i_clock,   // Core clock
	input  wire logic         i_arst_n,  // Async reset, active low
	input  wire logic         i_load,    // Start a count
	input  wire logic [W-1:0] i_value,   // Cycles minus one
	output logic              o_done     // Pulse at end of count
);

	typedef struct packed {
		logic         run;
		logic [W-1:0] cnt;
		logic         done;
	} ncph_tmr_s;

	ncph_tmr_s state_q;
	ncph_tmr_s state_d;

	always_comb begin
		state_d      = state_q;
		state_d.done = 1'b0;
		if (i_load) begin
			state_d.run = 1'b1;
			state_d.cnt = i_value;
		end else if (state_q.run) begin
			if (state_q.cnt == '0) begin
				state_d.run  = 1'b0;
				state_d.done = 1'b1;
			end else begin
				state_d.cnt = state_q.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign o_done = state_q.done;

endmodule // ncph_timer

// ---- verilog/ncph_top.sv ----
`timescale 1ns/1ps
module ncph_top
	import ncph_pkg::*;
(
	input  wire logic                 i_clock,     // 20 MHz, shared with host
	input  wire logic                 i_arst_n,    // Async reset, active low
	input  wire ncph_bus_s            i_bus,       // Host I/O cycle, one-cycle strobes
	input  wire logic [NCPH_NEXC-1:0] i_exc_cond,  // Conditions raised by the datapath
	output logic [NCPH_DW-1:0]        o_rdata,     // Read data
	output logic                      o_rvalid,    // Read data valid pulse
	output logic                      o_busy_n,    // Occupied, active low
	output logic                      o_operand_transfer_request, // Operand request
	output logic                      o_error_n    // Fault, active low
);

	typedef struct packed {
		ncph_state_e                state;
		logic [NCPH_DW-1:0]         cmd;
		logic [NCPH_NEXC-1:0]       mask;
		logic [NCPH_NEXC-1:0]       exc;
		logic [NCPH_BUF_AW-1:0]     idx;
		logic [NCPH_BUF_AW-1:0]     left;
		logic [NCPH_DW-1:0]         rdata;
		logic                       rvalid;
		logic                       busy_n;
		logic                       opreq;
		logic                       error_n;
	} ncph_core_s;

	ncph_core_s         state_q;
	ncph_core_s         state_d;
	logic [NCPH_DW-1:0] buf_q [2**NCPH_BUF_AW];
	logic               tmr_load;
	logic               tmr_done;
	logic               cmd_wr;
	logic               cmd_rd;
	logic               dat_wr;
	logic               dat_rd;
	logic               clr_wr;

	// Decode follows the host's port choice; bind the host
	assign cmd_wr = i_bus.wr && (i_bus.addr == NCPH_CMD_ADDR);
	assign cmd_rd = i_bus.rd && (i_bus.addr == NCPH_CMD_ADDR);
	assign dat_wr = i_bus.wr && (i_bus.addr == NCPH_DATA_ADDR);
	assign dat_rd = i_bus.rd && (i_bus.addr == NCPH_DATA_ADDR);
	assign clr_wr = i_bus.wr && (i_bus.addr == NCPH_CLEAR_ADDR)
		&& (i_bus.wdata[7:0] == NCPH_CLEAR_VAL);

	ncph_timer #(
		.W (NCPH_TMR_W)
	) u_exec_timer (
		.i_clock  (i_clock),
		.i_arst_n (i_arst_n),
		.i_load   (tmr_load),
		// Next-state copy, so a zero-operand command loads its own length
		.i_value  (state_d.cmd[NCPH_CMD_EXE_LSB +: NCPH_TMR_W]),
		.o_done   (tmr_done)
	);

	always_comb begin
		logic [NCPH_NEXC-1:0] unmasked;
		unmasked       = '0;
		state_d        = state_q;
		state_d.rvalid = 1'b0;
		tmr_load       = 1'b0;

		if (cmd_rd) begin
			state_d.rdata = '0;
			state_d.rdata[NCPH_ST_EXC_LSB +: NCPH_NEXC] = state_q.exc;
			state_d.rdata[NCPH_ST_ERR_BIT]  = ~state_q.error_n;
			state_d.rdata[NCPH_ST_BUSY_BIT] = ~state_q.busy_n;
			state_d.rvalid = 1'b1;
		end else if (dat_rd) begin
			state_d.rdata  = buf_q[state_q.idx];
			state_d.rvalid = 1'b1;
		end

		unique case (state_q.state)
			NCPH_IDLE: begin
				if (cmd_wr && i_bus.wdata[NCPH_CMD_LDCTL]) begin
					// Control load completes at once, no occupied phase
					state_d.mask = i_bus.wdata[NCPH_NEXC-1:0];
					if (i_bus.wdata[NCPH_CMD_CLREX]) begin
						state_d.exc = '0;
					end
				end else if (cmd_wr) begin
					state_d.cmd    = i_bus.wdata;
					state_d.busy_n = 1'b0;
					state_d.idx    = '0;
					state_d.left   = i_bus.wdata[NCPH_CMD_CNT_LSB +: NCPH_CMD_CNT_W];
					if (i_bus.wdata[NCPH_CMD_CNT_LSB +: NCPH_CMD_CNT_W] != '0) begin
						state_d.state = NCPH_XFER;
						state_d.opreq = 1'b1;
					end else begin
						state_d.state = NCPH_EXEC;
					end
				end
			end
			NCPH_XFER: begin
				// Host moves every word itself; the block only answers cycles
				if (dat_wr || dat_rd) begin
					state_d.idx  = state_q.idx + 1'b1;
					state_d.left = state_q.left - 1'b1;
					if (state_q.left == 3'h1) begin
						state_d.opreq = 1'b0;
						state_d.state = NCPH_EXEC;
					end
				end
			end
			NCPH_EXEC: begin
				if (tmr_done) begin
					state_d.state = NCPH_FINISH;
				end
			end
			NCPH_FINISH: begin
				unmasked    = i_exc_cond & ~state_q.mask;
				state_d.exc = state_q.exc | i_exc_cond;
				if (unmasked != '0) begin
					state_d.error_n = 1'b0;
					state_d.state   = NCPH_HELD;
				end else begin
					state_d.busy_n = 1'b1;
					state_d.state  = NCPH_IDLE;
				end
			end
			NCPH_HELD: begin
				if (clr_wr) begin
					state_d.busy_n  = 1'b1;
					state_d.error_n = 1'b1;
					state_d.state   = NCPH_IDLE;
				end
			end
		endcase

		// Timer starts on entry to execution, from either earlier state
		if (state_d.state == NCPH_EXEC && state_q.state != NCPH_EXEC) begin
			tmr_load = 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_q         <= '0;
			state_q.state   <= NCPH_IDLE;
			state_q.mask    <= NCPH_MASK_RST;
			state_q.busy_n  <= 1'b1;
			state_q.error_n <= 1'b1;
		end else begin
			state_q <= state_d;
		end
	end

	// Operand store; no reset so it maps to plain RAM
	always_ff @(posedge i_clock) begin
		if (dat_wr && state_q.state == NCPH_XFER) begin
			buf_q[state_q.idx] <= i_bus.wdata;
		end
	end

	assign o_rdata                    = state_q.rdata;
	assign o_rvalid                   = state_q.rvalid;
	assign o_busy_n                   = state_q.busy_n;
	assign o_operand_transfer_request = state_q.opreq;
	assign o_error_n                  = state_q.error_n;

endmodule // ncph_top

// ---- dv/ncph_checker_assertions.sv ----
`timescale 1ns/1ps
module ncph_checker
	import ncph_pkg::*;
(
	input wire logic                 i_clock,                    // Clock
	input wire logic                 i_arst_n,                   // Reset
	input wire ncph_bus_s            i_bus,                      // Host cycle
	input wire logic [NCPH_NEXC-1:0] i_exc_cond,                 // Conditions
	input wire logic [NCPH_DW-1:0]   o_rdata,                    // Read data
	input wire logic                 o_rvalid,                   // Read valid
	input wire logic                 o_busy_n,                   // Occupied
	input wire logic                 o_operand_transfer_request, // Request
	input wire logic                 o_error_n                   // Fault
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	wire start = i_bus.wr && i_bus.addr == NCPH_CMD_ADDR && !i_bus.wdata[15] && o_busy_n;
	wire clr = i_bus.wr && i_bus.addr == NCPH_CLEAR_ADDR && i_bus.wdata[7:0] == NCPH_CLEAR_VAL;
	wire rd_ok = i_bus.rd && (i_bus.addr == NCPH_CMD_ADDR || i_bus.addr == NCPH_DATA_ADDR);
	a_start_busy: assert property (start |=> !o_busy_n &&
		o_operand_transfer_request == ($past(i_bus.wdata[2:0]) != 3'h0)) else $error("start");
	a_req_in_busy: assert property (o_operand_transfer_request |-> !o_busy_n) else $error("req");
	a_req_first: assert property ($rose(o_busy_n) |-> !$past(o_operand_transfer_request))
		else $error("order");
	a_req_gap: assert property ($fell(o_operand_transfer_request) |-> !o_busy_n [*3])
		else $error("gap");
	a_fault_busy: assert property (!o_error_n |-> !o_busy_n) else $error("fault busy");
	a_fault_hold: assert property (!o_error_n && !clr |=> !o_error_n) else $error("hold");
	a_clear_both: assert property (clr && !o_error_n |=> o_busy_n && o_error_n)
		else $error("clear");
	a_read_answer: assert property (rd_ok |=> o_rvalid) else $error("read");
	a_read_only: assert property (o_rvalid |-> $past(rd_ok)) else $error("valid");
endmodule // ncph_checker

bind ncph_top ncph_checker ncph_checker_i (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_bus(i_bus),
	.i_exc_cond(i_exc_cond), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_busy_n(o_busy_n),
	.o_operand_transfer_request(o_operand_transfer_request), .o_error_n(o_error_n));

// ---- dv/ncph_host.sv ----
`timescale 1ns/1ps
module ncph_host
	import ncph_pkg::*;
(
	input wire logic               i_clock,  // Shared clock
	input wire logic               i_busy_n, // Occupied
	input wire logic               i_error_n, // Fault
	input wire logic [NCPH_DW-1:0] i_rdata,  // Read data
	input wire logic               i_rvalid, // Read valid
	output ncph_bus_s              o_bus     // Host cycle
);
	initial o_bus = '0;
	// Host owns every cycle; released lines are inverted so stale values never match
	task automatic access(input logic w, input logic [23:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic v);
		@(negedge i_clock);
		o_bus = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge i_clock);
		o_bus = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		q = i_rdata;
		v = i_rvalid;
	endtask
	task automatic wait_done(output logic ok, output int cyc);
		for (cyc = 0; cyc < 60 && i_busy_n !== 1'b1; cyc++) @(negedge i_clock);
		ok = (i_busy_n === 1'b1);
	endtask
	// Escape decode: a trapped escape never reaches the block; its vector is returned in vec
	task automatic escape(input logic [1:0] cr_flags, input int lim, input int off,
		input int len, input logic [15:0] cmd, output int vec);
		logic [15:0] q;
		logic        v;
		vec = 0;
		if (cr_flags != 2'b00) vec = 7;
		else if (i_error_n === 1'b0) vec = 16;
		else if (off + 1 > lim) vec = 13;
		else if (off + len - 1 > lim) vec = 9;
		else access(1'b1, NCPH_CMD_ADDR, cmd, q, v);
	endtask
endmodule // ncph_host

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	import ncph_pkg::*;
	logic i_clock = 1'b0;
	logic i_arst_n = 1'b0;
	logic [5:0] exc = 6'h00;
	ncph_bus_s bus;
	logic [15:0] rdata, q;
	logic rvalid, busy_n, req, err_n, v, ok;
	int cyc;
	int vec;
	int err_total = 0;
	int checks_done = 0;
	always #25 i_clock = ~i_clock;
	ncph_top ncph_top_i (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_bus(bus), .i_exc_cond(exc),
		.o_rdata(rdata), .o_rvalid(rvalid), .o_busy_n(busy_n),
		.o_operand_transfer_request(req), .o_error_n(err_n));
	ncph_host ncph_host_i (.i_clock(i_clock), .i_busy_n(busy_n), .i_error_n(err_n),
		.i_rdata(rdata), .i_rvalid(rvalid), .o_bus(bus));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic pins(input logic [2:0] exp);
		chk({13'h0, busy_n, req, err_n}, {13'h0, exp});
	endtask
	task automatic acc(input logic w, input logic [23:0] a, input logic [15:0] d);
		ncph_host_i.access(w, a, d, q, v);
	endtask
	task automatic test_done;
		$display("mismatches %0d, comparisons %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic s_reset;
		pins(3'b101);
		acc(1'b0, NCPH_CMD_ADDR, 16'h0000);
		chk({15'h0, v}, 16'h0001);
		chk(q, 16'h0000);
		acc(1'b0, 24'h8000f4, 16'h0000);
		chk({15'h0, v}, 16'h0000);
	endtask
	task automatic s_transfer;
		exc = 6'h3f;
		acc(1'b1, NCPH_CMD_ADDR, 16'h0102);
		pins(3'b011);
		acc(1'b1, NCPH_DATA_ADDR, 16'h1234);
		pins(3'b011);
		acc(1'b1, NCPH_DATA_ADDR, 16'h5678);
		pins(3'b001);
		ncph_host_i.wait_done(ok, cyc);
		chk({15'h0, ok}, 16'h0001);
		chk(16'(cyc), 16'h0004);
		pins(3'b101);
		acc(1'b1, NCPH_CMD_ADDR, 16'h0009);
		pins(3'b011);
		acc(1'b0, NCPH_DATA_ADDR, 16'h0000);
		chk({15'h0, v}, 16'h0001);
		chk(q, 16'h1234);
		pins(3'b001);
		ncph_host_i.wait_done(ok, cyc);
		chk(16'(cyc), 16'h0003);
	endtask
	task automatic s_escape;
		ncph_host_i.escape(2'b01, 1000, 0, 8, 16'h0000, vec);
		chk(16'(vec), 16'h0007);
		ncph_host_i.escape(2'b10, 1000, 0, 8, 16'h0000, vec);
		chk(16'(vec), 16'h0007);
		ncph_host_i.escape(2'b00, 1000, 1000, 8, 16'h0000, vec);
		chk(16'(vec), 16'h000d);
		ncph_host_i.escape(2'b00, 1000, 996, 8, 16'h0000, vec);
		chk(16'(vec), 16'h0009);
		pins(3'b101);
		ncph_host_i.escape(2'b00, 1000, 892, 108, 16'h0200, vec);
		chk(16'(vec), 16'h0000);
		ncph_host_i.wait_done(ok, cyc);
		chk(16'(cyc), 16'h0005);
	endtask
	task automatic s_fault(input int i);
		logic [5:0] m;
		m = 6'h01 << i;
		acc(1'b1, NCPH_CMD_ADDR, {10'h300, ~m});
		exc = ~m;
		acc(1'b1, NCPH_CMD_ADDR, 16'h0000);
		ncph_host_i.wait_done(ok, cyc);
		chk(16'(cyc), 16'h0003);
		pins(3'b101);
		exc = m;
		acc(1'b1, NCPH_CMD_ADDR, 16'h0000);
		for (int n = 0; n < 40 && err_n !== 1'b0; n++) @(negedge i_clock);
		pins(3'b000);
		ncph_host_i.escape(2'b00, 1000, 0, 8, 16'h0000, vec);
		chk(16'(vec), 16'h0010);
		pins(3'b000);
		acc(1'b0, NCPH_CMD_ADDR, 16'h0000);
		chk(q & 16'h8080, 16'h8080);
		acc(1'b1, NCPH_CLEAR_ADDR, 16'h0001);
		pins(3'b000);
		acc(1'b1, NCPH_CLEAR_ADDR, 16'hff00);
		pins(3'b101);
	endtask
	initial begin
		repeat (10) @(negedge i_clock);
		i_arst_n = 1'b1;
		s_reset();
		s_transfer();
		s_escape();
		for (int i = 0; i < NCPH_NEXC; i++) s_fault(i);
		test_done();
	end
	initial begin
		#(50 * 4000);
		err_total++;
		test_done();
	end
endmodule // testbench
